// file: verilog/p4gp_pkg.sv
// Purpose: Constants for the shared data-bus / general-purpose port
// Assumes: Byte-wide register port, 16-bit address
// Notes: Offsets are the low 16 bits of the register address
package p4gp_pkg;
    localparam int unsigned P4GP_WIDTH = 8;
    localparam int unsigned P4GP_ADDR_W = 16;
    localparam logic [15:0] P4GP_ADDR_DIR = 16'hFFC5;
    localparam logic [15:0] P4GP_ADDR_DATA = 16'hFFC7;
    localparam logic [15:0] P4GP_ADDR_PULLUP = 16'hFFDA;
    localparam logic [15:0] P4GP_ADDR_BUSCFG = 16'hFFC0;
    localparam logic [7:0] P4GP_RST_DIR = 8'h00;
    localparam logic [7:0] P4GP_RST_DATA = 8'h00;
    localparam logic [7:0] P4GP_RST_PULLUP = 8'h00;
    localparam logic [7:0] P4GP_DIR_READ = 8'hFF;
    localparam logic [7:0] P4GP_UNMAPPED = 8'h00;
    localparam logic [7:0] P4GP_BUSCFG_ALL8 = 8'hFF;
    localparam logic [7:0] P4GP_BUSCFG_ALL16 = 8'h00;
    localparam logic [1:0] P4GP_MODE_1 = 2'h0;
    localparam logic [1:0] P4GP_MODE_2 = 2'h1;
    localparam logic [1:0] P4GP_MODE_3 = 2'h2;
    localparam logic [1:0] P4GP_MODE_4 = 2'h3;
    typedef enum logic [1:0] {
        P4GP_ST_RESET = 2'h0,
        P4GP_ST_RUN = 2'h1,
        P4GP_ST_SWSTBY = 2'h3
    } p4gp_state_t;
endpackage

// file: verilog/p4gp_reg8.sv
// Purpose: One byte register with write and hardware-standby clear
// Assumes: Async active-low reset
// Notes: Software standby simply holds the value
module p4gp_reg8 #(
    parameter int unsigned WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic hw_standby_in,
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] wdata_in,
    output logic [WIDTH-1:0] value_out
);
    logic [WIDTH-1:0] value_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            value_q <= RST_VAL;
        else if (hw_standby_in)
            value_q <= RST_VAL;
        else if (wr_in)
            value_q <= wdata_in;
    end

    assign value_out = value_q;
endmodule

// file: verilog/p4gp_pinmux.sv
// Purpose: Per-pin output, enable and pull-up selection
// Assumes: Mode select already decoded
// Notes: One generate loop, one slice per pin
module p4gp_pinmux #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic bus16_in,
    input wire logic [WIDTH-1:0] dir_in,
    input wire logic [WIDTH-1:0] latch_in,
    input wire logic [WIDTH-1:0] pullup_in,
    input wire logic bus_oe_in,
    input wire logic [WIDTH-1:0] bus_dout_in,
    output logic [WIDTH-1:0] pin_o_out,
    output logic [WIDTH-1:0] pin_oe_out,
    output logic [WIDTH-1:0] pin_pu_out
);
    genvar i;
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
        assign pin_o_out[i] = bus16_in ? bus_dout_in[i] : latch_in[i];
        assign pin_oe_out[i] = bus16_in ? bus_oe_in : dir_in[i];
        assign pin_pu_out[i] = !bus16_in && pullup_in[i] && !dir_in[i];
    end
endmodule

// file: verilog/p4gp_port.sv
// Purpose: Eight-pin port, general-purpose I/O or low data-bus byte
// Assumes: Pins synchronous to clk_sys_in; single-cycle register strobes
// Notes: Read data stand only in the cycle after the read strobe
//
// What this block does
// - All areas byte-wide: port is general-purpose I/O under register control.
// - Any 16-bit area: pins become low byte of external data bus.
// - Byte-wide mode: direction 1 drives output, 0 makes input.
// - Direction register is write-only; reads return all ones.
// - Direction clears on reset and hardware standby, kept in software standby.
// - Bus config kept in software standby; byte-wide outputs keep driving there, 16-bit pins follow bus_oe_in.
// - Data read returns latch bit for output pins.
// - Data read returns pin level for input pins, in both modes.
// - Data latch clears on reset and hardware standby, kept in software standby.
// - Pull-up on only when enable 1 and direction 0, byte-wide mode.
// - Pull-up enable clears on reset and hardware standby, kept otherwise.
// - Pull-ups held off in 16-bit mode, software standby too.
// - 16-bit mode ignores direction; pins run as bidirectional bus.
// - Reset mode: byte-wide in modes 1 and 3, 16-bit in 2 and 4.
//
// Our own choice: the address-and-strobe port.
module p4gp_port #(
    parameter int unsigned WIDTH = p4gp_pkg::P4GP_WIDTH
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [1:0] op_mode_in,
    input wire logic hw_standby_in,
    input wire logic sw_standby_in,
    input wire logic [p4gp_pkg::P4GP_ADDR_W-1:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [WIDTH-1:0] pin_i_in,
    output logic [WIDTH-1:0] pin_o_out,
    output logic [WIDTH-1:0] pin_oe_out,
    output logic [WIDTH-1:0] pin_pu_out,
    input wire logic bus_oe_in,
    input wire logic [WIDTH-1:0] bus_dout_in,
    output logic [WIDTH-1:0] bus_din_out,
    output logic bus16_out
);
    p4gp_pkg::p4gp_state_t state_q;
    logic [7:0] buscfg_q;
    logic [7:0] rdata_q;
    logic [WIDTH-1:0] dir_w;
    logic [WIDTH-1:0] latch_w;
    logic [WIDTH-1:0] pullup_w;
    logic [WIDTH-1:0] port_read_w;
    logic bus16_w;
    logic wr_ok_w;
    logic strap_16_w;

    // Software writes refused while clock is notionally stopped
    assign wr_ok_w = reg_wr_in && !sw_standby_in && !hw_standby_in;
    assign strap_16_w = (op_mode_in == p4gp_pkg::P4GP_MODE_2) || (op_mode_in == p4gp_pkg::P4GP_MODE_4);

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_q <= p4gp_pkg::P4GP_ST_RESET;
        else if (hw_standby_in)
            state_q <= p4gp_pkg::P4GP_ST_RESET;
        else
        begin
            unique case (state_q)
                p4gp_pkg::P4GP_ST_RESET:
                    state_q <= p4gp_pkg::P4GP_ST_RUN;
                p4gp_pkg::P4GP_ST_RUN:
                    if (sw_standby_in)
                        state_q <= p4gp_pkg::P4GP_ST_SWSTBY;
                p4gp_pkg::P4GP_ST_SWSTBY:
                    if (!sw_standby_in)
                        state_q <= p4gp_pkg::P4GP_ST_RUN;
                default:
                    state_q <= p4gp_pkg::P4GP_ST_RESET;
            endcase
        end
    end

    // strap caught after release; held in software standby
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            buscfg_q <= p4gp_pkg::P4GP_BUSCFG_ALL8;
        else if (state_q == p4gp_pkg::P4GP_ST_RESET)
            buscfg_q <= strap_16_w ? p4gp_pkg::P4GP_BUSCFG_ALL16 : p4gp_pkg::P4GP_BUSCFG_ALL8;
        else if (wr_ok_w && reg_addr_in == p4gp_pkg::P4GP_ADDR_BUSCFG)
            buscfg_q <= reg_wdata_in;
    end

    // any zero bit marks a 16-bit area
    assign bus16_w = (state_q == p4gp_pkg::P4GP_ST_RESET) ? strap_16_w
                     : (buscfg_q != p4gp_pkg::P4GP_BUSCFG_ALL8);
    assign bus16_out = bus16_w;

    p4gp_reg8 #(.WIDTH(WIDTH), .RST_VAL(p4gp_pkg::P4GP_RST_DIR)) u_dir (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .hw_standby_in(hw_standby_in),
        .wr_in(wr_ok_w && reg_addr_in == p4gp_pkg::P4GP_ADDR_DIR),
        .wdata_in(reg_wdata_in[WIDTH-1:0]),
        .value_out(dir_w)
    );

    p4gp_reg8 #(.WIDTH(WIDTH), .RST_VAL(p4gp_pkg::P4GP_RST_DATA)) u_latch (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .hw_standby_in(hw_standby_in),
        .wr_in(wr_ok_w && reg_addr_in == p4gp_pkg::P4GP_ADDR_DATA),
        .wdata_in(reg_wdata_in[WIDTH-1:0]),
        .value_out(latch_w)
    );

    p4gp_reg8 #(.WIDTH(WIDTH), .RST_VAL(p4gp_pkg::P4GP_RST_PULLUP)) u_pullup (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .hw_standby_in(hw_standby_in),
        .wr_in(wr_ok_w && reg_addr_in == p4gp_pkg::P4GP_ADDR_PULLUP),
        .wdata_in(reg_wdata_in[WIDTH-1:0]),
        .value_out(pullup_w)
    );

    p4gp_pinmux #(.WIDTH(WIDTH)) u_mux (
        .bus16_in(bus16_w),
        .dir_in(dir_w),
        .latch_in(latch_w),
        .pullup_in(pullup_w),
        .bus_oe_in(bus_oe_in),
        .bus_dout_in(bus_dout_in),
        .pin_o_out(pin_o_out),
        .pin_oe_out(pin_oe_out),
        .pin_pu_out(pin_pu_out)
    );

    assign bus_din_out = pin_i_in;

    // latch for outputs, pin for inputs, both modes
    assign port_read_w = (dir_w & latch_w) | (~dir_w & pin_i_in);

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rdata_q <= p4gp_pkg::P4GP_UNMAPPED;
        else if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                p4gp_pkg::P4GP_ADDR_DIR:
                    rdata_q <= p4gp_pkg::P4GP_DIR_READ;
                p4gp_pkg::P4GP_ADDR_DATA:
                    rdata_q <= 8'(port_read_w);
                p4gp_pkg::P4GP_ADDR_PULLUP:
                    rdata_q <= 8'(pullup_w);
                p4gp_pkg::P4GP_ADDR_BUSCFG:
                    rdata_q <= buscfg_q;
                default:
                    rdata_q <= p4gp_pkg::P4GP_UNMAPPED;
            endcase
        end
        else
            rdata_q <= p4gp_pkg::P4GP_UNMAPPED;
    end

    assign reg_rdata_out = rdata_q;
endmodule

// file: tb/p4gp_pins_model.sv
// Purpose: Board side of the port pins
// Assumes: Pin levels settle once per clock
// Notes: A floating pin with no pull-up toggles, so it never reads as a stable value
module p4gp_pins_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] pin_o_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] pin_pu_in,
    input wire logic [7:0] ext_in,
    input wire logic [7:0] ext_oe_in,
    output logic [7:0] pin_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Plain always, so the port initialiser is not a second driver
    always @(posedge clk_sys_in)
        pin_out <= (pin_oe_in & pin_o_in) | (~pin_oe_in & ext_oe_in & ext_in)
            | (~pin_oe_in & ~ext_oe_in & (pin_pu_in | ~pin_out));
endmodule

// file: tb/p4gp_port_sva.sv
// Purpose: Port-level checks for the shared port
// Assumes: One clock, async active-low reset
// Notes: Pull-up register is not visible, only its gating
module p4gp_port_sva (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic hw_standby_in,
    input wire logic sw_standby_in,
    input wire logic [15:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] pin_i_in,
    input wire logic [7:0] pin_o_out,
    input wire logic [7:0] pin_oe_out,
    input wire logic [7:0] pin_pu_out,
    input wire logic bus_oe_in,
    input wire logic [7:0] bus_dout_in,
    input wire logic [7:0] bus_din_out,
    input wire logic bus16_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_dat;
    logic rd_map;
    assign rd_dat = reg_rd_in && reg_addr_in == 16'hFFC7;
    assign rd_map = reg_addr_in inside {16'hFFC5, 16'hFFC7, 16'hFFDA, 16'hFFC0};
    pu_wide_off_a: assert property (bus16_out |-> pin_pu_out == 8'h00) else $error("pull-up in wide mode");
    pu_input_a: assert property (!bus16_out |-> (pin_pu_out & pin_oe_out) == 8'h00) else $error("pull-up on output");
    bus_enable_a: assert property (bus16_out |-> pin_oe_out == {8{bus_oe_in}}) else $error("bus enable");
    bus_drive_a: assert property (bus16_out && bus_oe_in |-> pin_o_out == bus_dout_in) else $error("bus data");
    bus_input_a: assert property (bus_din_out == pin_i_in) else $error("bus input");
    dir_read_a: assert property (reg_rd_in && reg_addr_in == 16'hFFC5 |=> reg_rdata_out == 8'hFF) else $error("dir read");
    out_read_a: assert property (rd_dat && !bus16_out |=>
        ((reg_rdata_out ^ $past(pin_o_out)) & $past(pin_oe_out)) == 8'h00) else $error("latch read");
    in_read_a: assert property (rd_dat && !bus16_out |=>
        ((reg_rdata_out ^ $past(pin_i_in)) & ~$past(pin_oe_out)) == 8'h00) else $error("pin read");
    sw_hold_a: assert property (sw_standby_in && !hw_standby_in && !bus16_out |=>
        $stable(pin_oe_out) && $stable(pin_o_out)) else $error("standby drive lost");
    unmapped_a: assert property (reg_rd_in && !rd_map |=> reg_rdata_out == 8'h00) else $error("unmapped read");
    hw_clear_a: assert property (hw_standby_in |=>
        bus16_out || (pin_oe_out == 8'h00 && pin_pu_out == 8'h00)) else $error("hw standby clear");
    cover property (rd_dat && !bus16_out);
    cover property (bus16_out && bus_oe_in);
    cover property (sw_standby_in && pin_oe_out != 8'h00);
endmodule
bind p4gp_port p4gp_port_sva u_p4gp_sva (.*);

// file: tb/p4gp_port_tb.sv
// Purpose: Register-level tests of the shared port
// Assumes: Mode code 0 is byte-wide after reset
// Notes: Pins come back one cycle late through the board model
module p4gp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in = 1'b0, rst_n_in = 1'b0, hw = 1'b0, sw = 1'b0, wr = 1'b0, rd = 1'b0, boe = 1'b0, b16;
    logic [1:0] mode = 2'h0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wd = 8'h00, rdata, pin_i, pin_o, oe, pu, dout = 8'h00, din, ext = 8'h00, eoe = 8'hFF;
    int miscompares = 0, compares = 0;
    p4gp_port DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .op_mode_in(mode), .hw_standby_in(hw),
        .sw_standby_in(sw), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .pin_i_in(pin_i), .pin_o_out(pin_o), .pin_oe_out(oe), .pin_pu_out(pu),
        .bus_oe_in(boe), .bus_dout_in(dout), .bus_din_out(din), .bus16_out(b16));
    p4gp_pins_model u_pins (.clk_sys_in(clk_sys_in), .pin_o_in(pin_o), .pin_oe_in(oe), .pin_pu_in(pu),
        .ext_in(ext), .ext_oe_in(eoe), .pin_out(pin_i));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    // Fixed waits only, so a stuck design still reaches the verdict
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        miscompares++;
        results;
    end
    initial
    begin
        for (int m = 0; m < 5; m++)
        begin
            rst_n_in <= 1'b0;
            mode <= m[1:0] & {2{m < 4}};
            idle(2);
            rst_n_in <= 1'b1;
            idle(2);
            check({7'h00, b16}, {7'h00, m[0] && m < 4});
            rchk(16'hFFC0, {8{!(m[0] && m < 4)}});
        end
        $display("test strap done");
        ext <= 8'hA5;
        rchk(16'hFFC5, 8'hFF);
        rchk(16'hFFC7, 8'hA5);
        rchk(16'hFFDA, 8'h00);
        rchk(16'hFFC6, 8'h00);
        check(oe, 8'h00);
        wreg(16'hFFC5, 8'h0F);
        wreg(16'hFFC7, 8'h3C);
        rchk(16'hFFC7, 8'hAC);
        check(oe, 8'h0F);
        check(pin_o & 8'h0F, 8'h0C);
        eoe <= 8'h00;
        wreg(16'hFFDA, 8'hFF);
        idle(1);
        check(pu, 8'hF0);
        rchk(16'hFFC7, 8'hFC);
        $display("test port done");
        sw <= 1'b1;
        wreg(16'hFFC5, 8'h00);
        wreg(16'hFFDA, 8'h00);
        idle(1);
        check(oe, 8'h0F);
        check(pu, 8'hF0);
        sw <= 1'b0;
        hw <= 1'b1;
        idle(2);
        hw <= 1'b0;
        eoe <= 8'hFF;
        ext <= 8'h5A;
        idle(2);
        check(oe, 8'h00);
        rchk(16'hFFDA, 8'h00);
        rchk(16'hFFC7, 8'h5A);
        $display("test standby done");
        wreg(16'hFFC0, 8'h00);
        wreg(16'hFFC5, 8'hFF);
        boe <= 1'b1;
        dout <= 8'h96;
        idle(1);
        check({7'h00, b16}, 8'h01);
        check(oe, 8'hFF);
        check(pin_o, 8'h96);
        rchk(16'hFFC7, 8'h00);
        wreg(16'hFFDA, 8'hFF);
        wreg(16'hFFC5, 8'h00);
        boe <= 1'b0;
        sw <= 1'b1;
        idle(2);
        check(oe, 8'h00);
        check(pu, 8'h00);
        check(din, 8'h5A);
        wreg(16'hFFC0, 8'hFF);
        idle(1);
        check({7'h00, b16}, 8'h01);
        rchk(16'hFFC0, 8'h00);
        sw <= 1'b0;
        rchk(16'hFFC7, 8'h5A);
        $display("test wide bus done");
        results;
    end
endmodule
